//--- rtl/mds_sequencer.sv
// Measurement/display sequencer: gate, transfer, display period and reset.
//
// Summary of operation
// - Gate opens and closes on tap rising edges.
// - Transfer pulse of 70 ms copies count.
// - Transfer used only when store is selected.
// - Display period 0.2-7 s blocks new starts.
// - External hold freezes display and outputs.
// - Display end issues one reset pulse.
// - Timer held in measurement enable until a start arrives.
// - Manual start/stop bypasses automatic time base.
// - Stop mode: external reset enables one measurement.
// - Two record commands: one during sample, one during display.
// - Time base internal or external 100 kHz.
// - Five decade dividers, each divides by ten.
// - Reset presets dividers 87033 or 00033.
`timescale 1ns/10ps
`default_nettype none
module mds_sequencer (
  input  wire logic        clock,                    // 250 MHz system clock.
  input  wire logic        resetn,                   // Asynchronous reset, active low.
  input  wire logic        aclk_unused_tie,          // Spare input, not used.
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,             // Write address.
  input  wire logic        s_axi_awvalid,            // Write address valid.
  output logic             s_axi_awready,            // Write address ready.
  input  wire logic [31:0] s_axi_wdata,              // Write data.
  input  wire logic [3:0]  s_axi_wstrb,              // Write strobes.
  input  wire logic        s_axi_wvalid,             // Write data valid.
  output logic             s_axi_wready,             // Write data ready.
  output logic [1:0]       s_axi_bresp,              // Write response.
  output logic             s_axi_bvalid,             // Write response valid.
  input  wire logic        s_axi_bready,             // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,             // Read address.
  input  wire logic        s_axi_arvalid,            // Read address valid.
  output logic             s_axi_arready,            // Read address ready.
  output logic [31:0]      s_axi_rdata,              // Read data.
  output logic [1:0]       s_axi_rresp,              // Read response.
  output logic             s_axi_rvalid,             // Read data valid.
  input  wire logic        s_axi_rready,             // Read data ready.
  // Time base and link pins.
  input  wire logic        ref_tick_int,             // Internal 100 kHz reference level.
  input  wire logic        ref_tick_ext,             // External time-base level.
  input  wire logic        hold_n,                   // External display hold, active low.
  input  wire logic        ext_reset_pulse,          // External reset pulse for stop mode.
  output logic             counter_gate,             // Gate to the first counting decade.
  output logic             store_strobe,             // Copy counter into display storage.
  output logic             display_live,             // Storage bypassed, live count shown.
  output logic             measure_reset,            // Presets dividers, clears counters, overload.
  output logic             record_sample,            // Record command during sample.
  output logic             record_display,           // Record command during display.
  output logic             timebase_out              // Selected time base, for export.
);
  // Register byte addresses.
  localparam logic [7:0] REG_CTRL   = 8'h00;   // Control register.
  localparam logic [7:0] REG_DISP   = 8'h04;   // Display length in ticks.
  localparam logic [7:0] REG_STATUS = 8'h08;   // Sequencer status.
  // Control field positions.
  localparam int CTRL_EXT    = 0;   // Reference source select, 1 = external.
  localparam int CTRL_STORE  = 1;   // 1 = store, 0 = display.
  localparam int CTRL_MANUAL = 2;   // Manual operation.
  localparam int CTRL_START  = 3;   // Manual start (1) or stop (0).
  localparam int CTRL_STOPM  = 4;   // Sampling rate set to stop.
  localparam int CTRL_TAP    = 5;   // Three-bit sample period tap.
  localparam logic [7:0] CTRL_RESET = 8'h02;  // Store selected at reset.
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // Normal answer.
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Answer to unmapped address.

  logic [7:0]               ctrl;          // Control register.
  logic [mds_pkg::TMR_W-1:0] disp_len;     // Display length setting.
  mds_pkg::mds_state_t      state;         // Sequencer state.
  logic [mds_pkg::TMR_W-1:0] tmr;          // One-shot interval counter.
  logic                     ref_q;         // Selected reference, registered.
  logic                     ref_prev;      // Previous reference level.
  logic                     tick;          // One-cycle time-base enable.
  logic                     tap_level;     // Divider tap level.
  logic                     tap_prev;      // Previous tap level.
  logic                     tap_rise;      // Tap rising edge, the cycle after a tick or preset.
  logic                     armed;         // Stop mode: a start has been allowed.
  logic                     aw_hold;       // Write address captured.
  logic                     w_hold;        // Write data captured.
  logic [7:0]               aw_addr;       // Captured write address.
  logic [31:0]              w_data;        // Captured write data.
  logic [3:0]               w_strb;        // Captured strobes.

  // Decode of a register address, used for both reads and writes.
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == REG_CTRL) || (a == REG_DISP) || (a == REG_STATUS);
  endfunction : addr_ok

  // Pick the reference source and make a tick on its rising edge.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_q    <= 1'b0;
      ref_prev <= 1'b0;
      tick     <= 1'b0;
    end else begin
      ref_q    <= ctrl[CTRL_EXT] ? ref_tick_ext : ref_tick_int;
      ref_prev <= ref_q;
      tick     <= ref_q && !ref_prev;
    end
  end

  // The selected time base is exported from a flip-flop.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timebase_out <= 1'b0;
    end else begin
      timebase_out <= ref_q;
    end
  end

  // The chain is preset by the sequencer's own reset pulse.
  mds_decade_chain u_chain (
    .clock      (clock),
    .resetn     (resetn),
    .tick       (tick),
    .preset     (measure_reset),
    .preset_val (ctrl[CTRL_STOPM] ? mds_pkg::PRESET_STOP
                                  : mds_pkg::PRESET_AUTO),
    .tap        (ctrl[CTRL_TAP +: 3]),
    .tap_level  (tap_level)
  );

  // Tap edge detector; tap_prev follows tap_level every cycle, a preset included.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tap_prev <= 1'b0;
    end else begin
      tap_prev <= tap_level;
    end
  end
  assign tap_rise = tap_level && !tap_prev;

  // Main sequencer: gate, transfer, display, reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state         <= mds_pkg::MDS_WAIT;
      tmr           <= '0;
      counter_gate  <= 1'b0;
      store_strobe  <= 1'b0;
      measure_reset <= 1'b0;
    end else begin
      measure_reset <= 1'b0;
      case (state)
        mds_pkg::MDS_WAIT: begin
          // Timer held in measurement enable until a start arrives.
          // In stop mode an external reset pulse also resets the chain.
          if (!ctrl[CTRL_MANUAL] && ctrl[CTRL_STOPM] && ext_reset_pulse) begin
            measure_reset <= 1'b1;
          end
          if (ctrl[CTRL_MANUAL]) begin
            if (ctrl[CTRL_START]) begin
              counter_gate <= 1'b1;
              state        <= mds_pkg::MDS_SAMPLE;
            end
          end else if (tap_rise && (!ctrl[CTRL_STOPM] || armed)) begin
            counter_gate <= 1'b1;
            state        <= mds_pkg::MDS_SAMPLE;
          end
        end
        mds_pkg::MDS_SAMPLE: begin
          // Close on the next tap edge, or on manual stop.
          if (ctrl[CTRL_MANUAL] ? !ctrl[CTRL_START] : tap_rise) begin
            counter_gate <= 1'b0;
            store_strobe <= ctrl[CTRL_STORE];
            tmr          <= '0;
            state        <= mds_pkg::MDS_XFER;
          end
        end
        mds_pkg::MDS_XFER: begin
          // Transfer pulse of fixed length, counted in ticks.
          if (tick) begin
            if (tmr == mds_pkg::TMR_W'(mds_pkg::XFER_TICKS - 1)) begin
              store_strobe <= 1'b0;
              tmr          <= '0;
              state        <= mds_pkg::MDS_DISPLAY;
            end else begin
              tmr <= tmr + 1'b1;
            end
          end
        end
        mds_pkg::MDS_DISPLAY: begin
          // Display period: starts stay blocked; hold extends it.
          if (ctrl[CTRL_STOPM]) begin
            state <= mds_pkg::MDS_INHIBIT;
          end else if (tick && tmr < disp_len) begin
            tmr <= tmr + 1'b1;
          end else if (tmr >= disp_len && hold_n) begin
            measure_reset <= 1'b1;
            state         <= mds_pkg::MDS_WAIT;
          end
        end
        mds_pkg::MDS_INHIBIT: begin
          // Stop mode: bistable stays until the external reset.
          if (ext_reset_pulse && hold_n) begin
            measure_reset <= 1'b1;
            state         <= mds_pkg::MDS_WAIT;
          end
        end
        default: begin
          state <= mds_pkg::MDS_WAIT;
        end
      endcase
    end
  end

  // Stop-mode arming: each external reset allows one start.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      armed <= 1'b0;
    end else if (ext_reset_pulse) begin
      armed <= 1'b1;
    end else if (state == mds_pkg::MDS_SAMPLE) begin
      armed <= 1'b0;
    end
  end

  // Record commands and the live-display output.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      record_sample  <= 1'b0;
      record_display <= 1'b0;
      display_live   <= 1'b0;
    end else begin
      record_sample  <= (state == mds_pkg::MDS_SAMPLE);
      record_display <= (state == mds_pkg::MDS_DISPLAY) ||
                        (state == mds_pkg::MDS_INHIBIT);
      display_live   <= !ctrl[CTRL_STORE];
    end
  end

  // AXI write channel: address and data taken in either order.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;

  // Register writes and write response.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl         <= CTRL_RESET;
      disp_len     <= mds_pkg::TMR_W'(mds_pkg::DISP_MIN_TICKS);
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (aw_hold && w_hold && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr == REG_CTRL && w_strb[0]) begin
          ctrl <= w_data[7:0];
        end
        if (aw_addr == REG_DISP) begin
          // Clamp the display length to the documented range.
          if (w_data[mds_pkg::TMR_W-1:0] < mds_pkg::TMR_W'(mds_pkg::DISP_MIN_TICKS)) begin
            disp_len <= mds_pkg::TMR_W'(mds_pkg::DISP_MIN_TICKS);
          end else if (w_data[mds_pkg::TMR_W-1:0] > mds_pkg::TMR_W'(mds_pkg::DISP_MAX_TICKS)) begin
            disp_len <= mds_pkg::TMR_W'(mds_pkg::DISP_MAX_TICKS);
          end else begin
            disp_len <= w_data[mds_pkg::TMR_W-1:0];
          end
        end
      end
    end
  end

  // Read channel: one-cycle answer after the address is taken.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_CTRL:   s_axi_rdata <= {24'h0, ctrl};
        REG_DISP:   s_axi_rdata <= {12'h0, disp_len};
        REG_STATUS: s_axi_rdata <= {25'h0, armed, counter_gate, state};
        default:    s_axi_rdata <= 32'h0;
      endcase
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule : mds_sequencer
`default_nettype wire

//--- rtl/mds_pkg.sv
// Package with shared constants and types for the measure/display sequencer.
package mds_pkg;
  // Time base rate in hertz.
  localparam int unsigned TB_HZ            = 100000;
  // Transfer pulse length in milliseconds.
  localparam int unsigned XFER_MS          = 70;
  // Transfer pulse length in time-base ticks.
  localparam int unsigned XFER_TICKS       = (TB_HZ / 1000) * XFER_MS;
  // Shortest and longest display period in milliseconds.
  localparam int unsigned DISP_MIN_MS      = 200;
  localparam int unsigned DISP_MAX_MS      = 7000;
  // Display period bounds in time-base ticks.
  localparam int unsigned DISP_MIN_TICKS   = (TB_HZ / 1000) * DISP_MIN_MS;
  localparam int unsigned DISP_MAX_TICKS   = (TB_HZ / 1000) * DISP_MAX_MS;
  // Width of the display and transfer counters.
  localparam int unsigned TMR_W            = 20;
  // Number of divider decades and digits in the preset.
  localparam int unsigned N_DEC            = 5;
  // Divider preset after reset in automatic sampling, as five bcd digits.
  localparam logic [19:0] PRESET_AUTO      = 20'h87033;
  // Divider preset after reset in stop mode.
  localparam logic [19:0] PRESET_STOP      = 20'h00033;
  // Highest digit value of a decade.
  localparam logic [3:0]  DIGIT_MAX        = 4'h9;
  // Selectable sample period codes: tap of the divider chain.
  localparam logic [2:0]  TAP_MAX          = 3'h4;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    MDS_WAIT    = 5'b00001,
    MDS_SAMPLE  = 5'b00010,
    MDS_XFER    = 5'b00100,
    MDS_DISPLAY = 5'b01000,
    MDS_INHIBIT = 5'b10000
  } mds_state_t;
endpackage : mds_pkg

//--- rtl/mds_decade_chain.sv
// Five presettable decade dividers in series with a selectable output tap.
`timescale 1ns/10ps
`default_nettype none
module mds_decade_chain (
  input  wire logic        clock,       // System clock.
  input  wire logic        resetn,      // Asynchronous reset, active low.
  input  wire logic        tick,        // Time-base enable pulse.
  input  wire logic        preset,      // Loads the preset value.
  input  wire logic [19:0] preset_val,  // Five bcd digits, low digit first.
  input  wire logic [2:0]  tap,         // Selected decade output.
  output logic             tap_level    // Square-wave level at the tap.
);
  logic [3:0] digit [mds_pkg::N_DEC];    // Decade contents.
  logic [mds_pkg::N_DEC:0] carry;        // Carry into each decade.

  assign carry[0] = tick;

  // Each decade counts 0..9 and carries to the next one on wrap.
  genvar g;
  generate
    for (g = 0; g < mds_pkg::N_DEC; g++) begin : g_dec
      assign carry[g+1] = carry[g] && (digit[g] == mds_pkg::DIGIT_MAX);
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          digit[g] <= 4'h0;
        end else if (preset) begin
          digit[g] <= preset_val[4*g +: 4];
        end else if (carry[g]) begin
          digit[g] <= (digit[g] == mds_pkg::DIGIT_MAX) ? 4'h0 : digit[g] + 4'h1;
        end
      end
    end
  endgenerate

  // The tap is high for digits 5..9, a square wave at a tenth of its input.
  always_comb begin
    tap_level = (digit[(tap > mds_pkg::TAP_MAX) ? mds_pkg::TAP_MAX : tap] >= 4'h5);
  end
endmodule : mds_decade_chain
`default_nettype wire

//--- sim/mds_seq_monitor.sv
// Port checker for the measure/display sequencer, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module mds_seq_monitor (
  input wire logic clock,           // System clock.
  input wire logic resetn,          // Asynchronous reset, active low.
  input wire logic hold_n,          // Display hold from the recorder.
  input wire logic counter_gate,    // Gate to the first counting decade.
  input wire logic store_strobe,    // Transfer into display storage.
  input wire logic display_live,    // Live count selected.
  input wire logic measure_reset,   // Reset pulse to dividers and counters.
  input wire logic record_sample,   // Record command during sample.
  input wire logic record_display   // Record command during display.
);
  // All checks use the system clock and rest while reset is low.
  default clocking mon_cb @(posedge clock); endclocking
  default disable iff (!resetn);
  pulse_single_a: assert property (measure_reset |=> !measure_reset)
    else $error("Reset pulse lasted more than one cycle.");
  reset_gate_a: assert property (measure_reset |-> ##[0:2] !counter_gate)
    else $error("Reset pulse left the gate open.");
  xfer_follow_a: assert property ($fell(counter_gate) && !display_live |-> ##[0:4] store_strobe)
    else $error("No transfer after the sample period.");
  xfer_hold_a: assert property ($rose(store_strobe) |=> store_strobe [*8])
    else $error("Transfer pulse ended too soon.");
  live_nostore_a: assert property (display_live |-> !store_strobe)
    else $error("Transfer seen with live display.");
  busy_nostart_a: assert property (store_strobe || record_display |-> !counter_gate)
    else $error("Gate open during transfer or display.");
  hold_freeze_a: assert property (!hold_n && record_display |=> record_display && !measure_reset)
    else $error("Display ended while hold was active.");
  rec_sample_a: assert property ($rose(counter_gate) |-> ##[0:2] record_sample)
    else $error("Sample record command missing.");
  rec_excl_a: assert property (!(record_sample && record_display))
    else $error("Both record commands active.");
  // Main scenarios seen.
  gate_c: cover property ($rose(counter_gate));
  xfer_c: cover property ($rose(store_strobe));
  reset_c: cover property (measure_reset);
  hold_c: cover property (!hold_n && record_display);
endmodule : mds_seq_monitor
bind mds_sequencer mds_seq_monitor mds_seq_monitor_i (.clock(clock), .resetn(resetn),
  .hold_n(hold_n), .counter_gate(counter_gate), .store_strobe(store_strobe),
  .display_live(display_live), .measure_reset(measure_reset),
  .record_sample(record_sample), .record_display(record_display));
`default_nettype wire

//--- sim/mds_recorder_model.sv
// Recorder model that holds the display for a chosen number of cycles.
`timescale 1ns/10ps
`default_nettype none
module mds_recorder_model (
  input  wire logic        clock,           // System clock.
  input  wire logic        resetn,          // Asynchronous reset, active low.
  input  wire logic        record_display,  // Display record command.
  input  wire logic [31:0] hold_len,        // Hold length in cycles, zero for none.
  output logic             hold_n           // Hold output, active low.
);
  logic        prev;  // Last record command level.
  logic [31:0] cnt;   // Cycles of hold left.
  // Pull the hold low when a display period starts, then release it.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prev   <= 1'b0;
      cnt    <= 32'h0;
      hold_n <= 1'b1;
    end else begin
      prev <= record_display;
      if (record_display && !prev && hold_len != 32'h0) begin
        cnt    <= hold_len;
        hold_n <= 1'b0;
      end else if (cnt > 32'h1) begin
        cnt <= cnt - 32'h1;
      end else begin
        cnt    <= 32'h0;
        hold_n <= 1'b1;
      end
    end
  end
endmodule : mds_recorder_model
`default_nettype wire

//--- sim/tb_mds_sequencer.sv
// Self-checking testbench of the measure/display sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_mds_sequencer;
  logic        clock = 1'b0, resetn = 1'b0, run_ref = 1'b0;          // Clock, reset, tick enable.
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;                        // Bus addresses.
  logic [31:0] wdata = 32'h0, hold_len = 32'h0, v, v2;                // Data and results.
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;          // Write handshakes.
  logic        arvalid = 1'b0, rready = 1'b0;                         // Read handshakes.
  logic        awready, wready, bvalid, arready, rvalid, hold_n;      // Design handshakes.
  logic [1:0]  bresp, rresp, resp;                                    // Responses.
  logic [31:0] rdata;                                                 // Read data.
  logic        ref_int = 1'b0, ref_ext = 1'b0, ext_rst = 1'b0;        // Time base and reset pins.
  logic        gate, strobe, live, mreset, rec_s, rec_d, tb_out;      // Sequencer outputs.
  int          fail_count = 0, checks = 0, cycles = 0, seed = 28158, n;
  logic [31:0] corner [4] = '{32'h0, 32'h4e1f, 32'haae60, 32'haae61}; // Clamp edge values.
  always #2 clock = ~clock;
  // Fast time base: one tick every two cycles keeps the run short.
  always @(posedge clock) ref_int <= run_ref ? ~ref_int : ref_int;
  // Hang guard.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      fail_count++;
      stop_test();
    end
  end
  mds_sequencer mds_sequencer_i (.clock(clock), .resetn(resetn), .aclk_unused_tie(1'b0),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ref_tick_int(ref_int), .ref_tick_ext(ref_ext), .hold_n(hold_n),
    .ext_reset_pulse(ext_rst), .counter_gate(gate), .store_strobe(strobe),
    .display_live(live), .measure_reset(mreset), .record_sample(rec_s),
    .record_display(rec_d), .timebase_out(tb_out));
  mds_recorder_model mds_recorder_model_i (.clock(clock), .resetn(resetn),
    .record_display(rec_d), .hold_len(hold_len), .hold_n(hold_n));
  // Ticks to cycles at the bench time base.
  function automatic int cyc(input int t);
    return t * 2;
  endfunction : cyc
  // Expected display length after clamping.
  function automatic logic [31:0] clamp(input logic [31:0] x);
    if (x < mds_pkg::DISP_MIN_TICKS) return mds_pkg::DISP_MIN_TICKS;
    if (x > mds_pkg::DISP_MAX_TICKS) return mds_pkg::DISP_MAX_TICKS;
    return x;
  endfunction : clamp
  // Compares and counts.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One bus write; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask : wr
  // One bus read.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask : rd
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(8'h00, v, resp);
    check("ctrl_reset", v, 32'h2);
    rd(8'h04, v, resp);
    check("disp_reset", v, mds_pkg::DISP_MIN_TICKS);
    rd(8'h0c, v, resp);
    check("unmapped_rresp", resp, 2'h2);
    check("unmapped_rdata", v, 32'h0);
    wr(8'h10, 32'h0, resp);
    check("unmapped_bresp", resp, 2'h2);
    // Display lengths: corners, then random values.
    for (int i = 0; i < 7; i++) begin
      v = (i < 4) ? corner[i] : ($random(seed) & 32'h000fffff);
      wr(8'h04, v, resp);
      rd(8'h04, v2, resp);
      check("disp_len", v2, clamp(v));
    end
    wr(8'h04, mds_pkg::DISP_MIN_TICKS, resp);
    $display("Test registers done");
    wr(8'h00, 32'h01, resp);
    repeat (6) @(posedge clock);
    check("tb_ext_low", tb_out, 1'b0);
    ref_ext <= 1'b1;
    repeat (6) @(posedge clock);
    check("tb_ext_high", tb_out, 1'b1);
    wr(8'h00, 32'h02, resp);
    run_ref <= 1'b1;
    repeat (6) @(posedge clock);
    v[0] = tb_out;
    @(posedge clock);
    check("tb_int", tb_out, !v[0]);
    $display("Test time base done");
    // Automatic cycle in store mode with the recorder holding the display.
    hold_len <= 32'd42000 + ($random(seed) & 32'h3ff);
    while (gate !== 1'b1) @(posedge clock);
    n = 0;
    while (gate === 1'b1) begin
      @(posedge clock);
      n++;
    end
    check("gate_len", n, cyc(10));
    while (strobe !== 1'b1) @(posedge clock);
    n = 0;
    while (strobe === 1'b1) begin
      @(posedge clock);
      n++;
    end
    check("xfer_len", n > cyc(mds_pkg::XFER_TICKS) - 4 && n < cyc(mds_pkg::XFER_TICKS) + 4, 1);
    while (rec_d !== 1'b1) @(posedge clock);
    n = 0;
    while (mreset !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    check("disp_hold", n >= hold_len && n <= hold_len + 40, 1);
    n = 0;
    while (gate !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    check("restart", n > 0 && n < cyc(13000), 1);
    $display("Test auto cycle done");
    wr(8'h00, 32'h0c, resp);
    while (gate !== 1'b1) @(posedge clock);
    check("live", live, 1'b1);
    n = 0;
    repeat (100) begin
      @(posedge clock);
      n += (gate === 1'b1);
    end
    check("manual_open", n, 100);
    wr(8'h00, 32'h04, resp);
    repeat (4) @(posedge clock);
    check("manual_stop", gate, 1'b0);
    resetn <= 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    $display("Test manual done");
    // Stop mode: one start for each external reset pulse.
    hold_len <= 32'h0;
    wr(8'h00, 32'h12, resp);
    repeat (300) @(posedge clock);
    check("stop_idle", gate, 1'b0);
    ext_rst <= 1'b1;
    @(posedge clock);
    ext_rst <= 1'b0;
    n = 0;
    while (mreset !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    check("ext_reset", n < 8, 1);
    while (gate !== 1'b1) @(posedge clock);
    rd(8'h08, v, resp);
    check("status_sample", v[5:0], 6'h22);
    check("rec_sample", rec_s, 1'b1);
    while (strobe !== 1'b1) @(posedge clock);
    while (strobe === 1'b1) @(posedge clock);
    n = 0;
    repeat (3000) begin
      @(posedge clock);
      n += (gate === 1'b1);
    end
    check("inhibit", n, 0);
    rd(8'h08, v, resp);
    check("status_inhibit", v[4:0], 5'h10);
    $display("Test stop mode done");
    stop_test();
  end
endmodule : tb_mds_sequencer
`default_nettype wire
